// *** bfg_guard.sv ***
// Boot section flash guard: store/load arbitration, locks and bus slave
`timescale 1ns/1ns
module bfg_guard
  import bfg_pkg::*;
(
  // Clock and synchronous reset
  input  wire logic           clock,
  input  wire logic           rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]     address,
  input  wire logic           read,
  input  wire logic           write,
  input  wire logic [31:0]    writedata,
  input  wire logic [3:0]     byteenable,
  output logic      [31:0]    readdata,
  output logic                waitrequest,
  // Core execution unit (same clock)
  input  wire logic [12:0]    exec_addr,
  input  wire bfg_store_req_t store_req,
  output logic                store_grant,
  input  wire logic           load_req,
  input  wire logic [12:0]    load_addr,
  output logic                load_grant,
  input  wire logic [12:0]    fetch_addr,
  output logic                fetch_allow,
  output logic                core_stall,
  output logic                irq_suppress,
  // Flash array control (same clock)
  output logic                prog_start,
  output bfg_store_kind_t     prog_kind,
  output logic [12:0]         prog_addr,
  input  wire logic           prog_done,
  // Fuse and external programming pins (asynchronous)
  input  wire logic [1:0]     boot_size_fuses,
  input  wire logic           chip_erase,
  input  wire logic           lock_pgm_strobe,
  input  wire logic [3:0]     lock_pgm_data
);

  // All state of the block
  typedef struct packed {
    bfg_prog_state_t ps;
    logic            busy;
    bfg_lock_t       app_lock;
    bfg_lock_t       boot_lock;
    logic            vec_boot;
    logic            ack;
    logic [31:0]     rdata;
    logic            start;
    bfg_store_kind_t kind;
    logic [12:0]     paddr;
    logic [1:0]      fuse_s1;
    logic [1:0]      fuse_s2;
    logic [1:0]      erase_s;
    logic            erase_s3;
    logic [1:0]      lstb_s;
    logic            lstb_s3;
    logic [3:0]      ldat_s1;
    logic [3:0]      ldat_s2;
  } bfg_state_t;

  bfg_state_t s_q;
  bfg_state_t s_d;

  logic [12:0] boot_start;
  logic        exec_boot;
  logic        tgt_boot;
  logic        tgt_conc;
  logic        ld_boot;
  logic        ld_conc;
  logic        fetch_conc;
  logic        store_ok;
  logic        load_ok;
  logic        bus_req;
  logic        wr_take;
  logic        erase_pulse;
  logic        lpgm_pulse;
  logic [3:0]  sw_lock_new;

  // Boot region start from the synchronised fuses; every choice sits at or
  // above the halting region start so the boot region stays inside it
  always_comb begin
    case (s_q.fuse_s2)
      2'b00:   boot_start = BOOT_START_0;
      2'b01:   boot_start = BOOT_START_1;
      2'b10:   boot_start = BOOT_START_2;
      2'b11:   boot_start = BOOT_START_3;
      default: boot_start = BOOT_START_0;
    endcase
  end

  // Region decode of executing code, store target, load target and fetch
  assign exec_boot  = exec_addr >= boot_start;
  assign tgt_boot   = store_req.addr >= boot_start;
  assign tgt_conc   = store_req.addr < HALT_START;
  assign ld_boot    = load_addr >= boot_start;
  assign ld_conc    = load_addr < HALT_START;
  assign fetch_conc = fetch_addr < HALT_START;

  // Store judgement. General lock levels have no input here at all, so
  // they cannot gate stores or loads. A low lock bit of zero (modes 2, 3)
  // blocks page erase and write into that region.
  always_comb begin
    store_ok = 1'b0;
    if (store_req.valid && exec_boot && s_q.ps == PS_IDLE) begin
      case (store_req.kind)
        ST_BUF_LOAD:   store_ok = 1'b1;
        ST_LOCK_SET:   store_ok = 1'b1;
        ST_PAGE_ERASE,
        ST_PAGE_WRITE: begin
          // Boot code may reach any page, boot pages too
          if (tgt_boot) begin
            store_ok = s_q.boot_lock.low;
          end else begin
            store_ok = s_q.app_lock.low;
          end
        end
        default:       store_ok = 1'b0;
      endcase
    end
  end

  // Load judgement: cross-region loads blocked when the high bit is zero
  // (modes 3, 4); nothing readable during halting-region programming and
  // no concurrent-region read while the busy flag stands
  always_comb begin
    load_ok = 1'b1;
    if (s_q.ps == PS_HALT) begin
      load_ok = 1'b0;
    end else if (s_q.busy && ld_conc) begin
      load_ok = 1'b0;
    end else if (exec_boot && !ld_boot && !s_q.app_lock.high) begin
      load_ok = 1'b0;
    end else if (!exec_boot && ld_boot && !s_q.boot_lock.high) begin
      load_ok = 1'b0;
    end
  end

  // Grants are pure combinational answers; a refused request changes no
  // state, which keeps the core's retry semantics simple
  assign store_grant = store_ok;
  assign load_grant  = load_req && load_ok;

  // Fetch is allowed from the halting region during concurrent programming
  assign fetch_allow = (s_q.ps != PS_HALT) &&
                       !(s_q.busy && fetch_conc);
  assign core_stall  = s_q.ps == PS_HALT;

  // Interrupts muted when the vectors sit in the other region and the lock of
  // the region where the core now executes forbids loads of it from there
  assign irq_suppress =
    (!s_q.app_lock.high && s_q.vec_boot && !exec_boot) ||
    (!s_q.boot_lock.high && !s_q.vec_boot && exec_boot);

  // Flash array command comes straight from registers
  assign prog_start = s_q.start;
  assign prog_kind  = s_q.kind;
  assign prog_addr  = s_q.paddr;

  // Bus slave: one wait cycle for every access, answer on the second
  assign bus_req     = read || write;
  assign waitrequest = bus_req && !s_q.ack;
  assign wr_take     = write && s_q.ack;
  assign readdata    = s_q.rdata;

  // Synchronised edge pulses from the external programming pins
  assign erase_pulse = s_q.erase_s[1] && !s_q.erase_s3;
  assign lpgm_pulse  = s_q.lstb_s[1] && !s_q.lstb_s3;

  // Software lock writes can only program bits: ones never come back
  assign sw_lock_new = writedata[3:0] &
                       {s_q.boot_lock, s_q.app_lock};

  // Next-state logic for the whole block
  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;

    // Two flip-flop synchronisers; the second stage is read, and the erase and strobe pins also feed a third stage for edges
    s_d.fuse_s1  = boot_size_fuses;
    s_d.fuse_s2  = s_q.fuse_s1;
    s_d.erase_s  = {s_q.erase_s[0], chip_erase};
    s_d.erase_s3 = s_q.erase_s[1];
    s_d.lstb_s   = {s_q.lstb_s[0], lock_pgm_strobe};
    s_d.lstb_s3  = s_q.lstb_s[1];
    s_d.ldat_s1  = lock_pgm_data;
    s_d.ldat_s2  = s_q.ldat_s1;

    // Bus answer: ack one cycle after the request, then drop
    s_d.ack = bus_req && !s_q.ack;
    if (bus_req && !s_q.ack) begin
      s_d.rdata = 32'h0000_0000;
      case (address)
        REG_STATUS: begin
          s_d.rdata[ST_BUSY_BIT]  = s_q.busy;
          s_d.rdata[ST_CONC_BIT]  = s_q.ps == PS_CONC;
          s_d.rdata[ST_STALL_BIT] = s_q.ps == PS_HALT;
        end
        REG_LOCK: begin
          s_d.rdata[LK_APP_LSB+:2]  = s_q.app_lock;
          s_d.rdata[LK_BOOT_LSB+:2] = s_q.boot_lock;
        end
        REG_CONFIG: begin
          s_d.rdata[CF_VEC_BIT]    = s_q.vec_boot;
          s_d.rdata[CF_FUSE_LSB+:2] = s_q.fuse_s2;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Software writes, taken at the edge where waitrequest is low
    if (wr_take && byteenable[0]) begin
      case (address)
        REG_STATUS: begin
          // Read-enable only clears the flag once programming is over
          if (writedata[ST_RDEN_BIT] && s_q.ps == PS_IDLE) begin
            s_d.busy = 1'b0;
          end
        end
        REG_LOCK: begin
          {s_d.boot_lock, s_d.app_lock} = sw_lock_new;
        end
        REG_CONFIG: s_d.vec_boot = writedata[CF_VEC_BIT];
        default: s_d.vec_boot = s_q.vec_boot;
      endcase
    end

    // Serial or parallel programming mode may also only program bits
    if (lpgm_pulse) begin
      {s_d.boot_lock, s_d.app_lock} =
        {s_d.boot_lock, s_d.app_lock} & s_q.ldat_s2;
    end

    // Granted store requests
    if (store_ok) begin
      case (store_req.kind)
        ST_BUF_LOAD: begin
          s_d.busy  = 1'b0;
          s_d.start = 1'b1;
          s_d.kind  = store_req.kind;
          s_d.paddr = store_req.addr;
        end
        ST_LOCK_SET: begin
          {s_d.boot_lock, s_d.app_lock} =
            {s_d.boot_lock, s_d.app_lock} & store_req.lock_data;
        end
        default: begin
          s_d.start = 1'b1;
          s_d.kind  = store_req.kind;
          s_d.paddr = store_req.addr;
        end
      endcase
    end

    // Chip erase and reset are the only ways to return locks to unprogrammed
    if (erase_pulse) begin
      s_d.app_lock  = LOCK_UNPROG;
      s_d.boot_lock = LOCK_UNPROG;
    end

    // Programming sequencer: the page's region picks stall or not
    case (s_q.ps)
      PS_IDLE: begin
        if (store_ok && (store_req.kind == ST_PAGE_ERASE ||
                         store_req.kind == ST_PAGE_WRITE)) begin
          if (tgt_conc) begin
            s_d.ps   = PS_CONC;
            s_d.busy = 1'b1;
          end else begin
            s_d.ps = PS_HALT;
          end
        end
      end
      PS_CONC: begin
        // Busy flag stays set after completion until software clears it
        if (prog_done) begin
          s_d.ps = PS_IDLE;
        end
      end
      PS_HALT: begin
        if (prog_done) begin
          s_d.ps = PS_IDLE;
        end
      end
      default: s_d.ps = PS_IDLE;
    endcase
  end

  // State register; locks are held in nonvolatile cells in silicon, here
  // they reset to unprogrammed so simulation starts from a known point
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.ps        <= PS_IDLE;
      s_q.app_lock  <= LOCK_UNPROG;
      s_q.boot_lock <= LOCK_UNPROG;
      s_q.vec_boot  <= VEC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// *** bfg_pkg.sv ***
// Constants, types and register map of the boot section flash guard
//
// Overview of operation
// - Store requests executing from the application region are ignored
// - Boot region code may target any page, boot region included
// - Concurrent region programming keeps core running, halting region readable
// - Halting region programming stalls core; nothing readable until done
// - Busy flag reads one while concurrent region is blocked for reading
// - Boot region always lies wholly inside the halting region
// - Stall decided by region of page programmed, not fetch region
// - Boot size fuses set region sizes; each region has own lock field
// - Lock bits only get programmed; chip erase and reset alone clear them
// - General write and read/write lock levels do not gate stores/loads
// - Lock bits are inverted: one unprogrammed, zero programmed
// - Application lock mode 1 leaves application accesses unrestricted
// - Application lock modes 2 and 3 block stores into application
// - Application modes 3 and 4 block boot-code loads of application
// - Application modes 3,4 with boot vectors mute interrupts in application
// - Boot lock mode 1 leaves boot region accesses unrestricted
// - Boot lock modes 2 and 3 block stores into boot region
// - Boot modes 3 and 4 block application-code loads of boot region
// - Boot modes 3,4 with application vectors mute interrupts in boot
// - Busy flag clears on read-enable write when idle, or buffer load
package bfg_pkg;

  // Flash word address: 16K bytes as 8K words
  localparam int unsigned ADDR_W = 13;

  // Fixed start of the halting region (word address)
  localparam logic [12:0] HALT_START = 13'h1c00;

  // Boot region start per boot size fuse code, all inside halting region
  localparam logic [12:0] BOOT_START_0 = 13'h1c00;
  localparam logic [12:0] BOOT_START_1 = 13'h1e00;
  localparam logic [12:0] BOOT_START_2 = 13'h1f00;
  localparam logic [12:0] BOOT_START_3 = 13'h1f80;

  // Register byte offsets on the bus
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_LOCK   = 4'h4;
  localparam logic [3:0] REG_CONFIG = 4'h8;

  // Status register fields
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_CONC_BIT  = 1;
  localparam int unsigned ST_STALL_BIT = 2;
  localparam int unsigned ST_RDEN_BIT  = 4;

  // Lock register fields (two bits each)
  localparam int unsigned LK_APP_LSB  = 0;
  localparam int unsigned LK_BOOT_LSB = 2;

  // Config register fields
  localparam int unsigned CF_VEC_BIT  = 0;
  localparam int unsigned CF_FUSE_LSB = 4;

  // Reset values: locks unprogrammed, vectors in application region
  localparam logic [1:0] LOCK_UNPROG = 2'h3;
  localparam logic       VEC_RESET   = 1'h0;

  // Kind of store-program request issued by the core
  typedef enum logic [1:0] {
    ST_BUF_LOAD   = 2'b00,
    ST_PAGE_ERASE = 2'b01,
    ST_PAGE_WRITE = 2'b10,
    ST_LOCK_SET   = 2'b11
  } bfg_store_kind_t;

  // Programming sequencer
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_CONC = 2'b01,
    PS_HALT = 2'b10
  } bfg_prog_state_t;

  // Two-bit lock field: high bit and low bit
  typedef struct packed {
    logic high;
    logic low;
  } bfg_lock_t;

  // Store request from the core
  typedef struct packed {
    logic            valid;
    bfg_store_kind_t kind;
    logic [12:0]     addr;
    logic [3:0]      lock_data;
  } bfg_store_req_t;

endpackage

// *** bfg_guard_asserts.sv ***
// Concurrent checks on the guard's core and flash ports
`timescale 1ns/1ns
module bfg_guard_asserts
  import bfg_pkg::*;
(
  // Clock and reset
  input wire logic           clock,
  input wire logic           rst_n,
  // Core and flash ports
  input wire logic [12:0]    exec_addr,
  input wire bfg_store_req_t store_req,
  input wire logic           store_grant,
  input wire logic           load_req,
  input wire logic           load_grant,
  input wire logic [12:0]    fetch_addr,
  input wire logic           fetch_allow,
  input wire logic           core_stall,
  input wire logic           prog_start,
  input wire logic           prog_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Accepted erase or write, split by the region of the target page
  sequence s_prog;
    store_grant && store_req.kind inside {ST_PAGE_ERASE, ST_PAGE_WRITE};
  endsequence
  sequence s_halt_pg;
    s_prog ##0 store_req.addr >= HALT_START;
  endsequence
  sequence s_conc_pg;
    s_prog ##0 store_req.addr < HALT_START;
  endsequence
  property p_halt; s_halt_pg |=> core_stall && prog_start; endproperty
  a_halt: assert property (p_halt) else $error("no stall");
  property p_conc; s_conc_pg |=> !core_stall && prog_start; endproperty
  a_conc: assert property (p_conc) else $error("bad stall");
  property p_hold; core_stall && !prog_done |=> core_stall; endproperty
  a_hold: assert property (p_hold) else $error("stall dropped");
  property p_end; core_stall && prog_done |=> !core_stall; endproperty
  a_end: assert property (p_end) else $error("stall stuck");
  property p_fstall; core_stall |-> !fetch_allow && !load_grant; endproperty
  a_fstall: assert property (p_fstall) else $error("read in stall");
  property p_fhalt;
    !core_stall && fetch_addr >= HALT_START |-> fetch_allow;
  endproperty
  a_fhalt: assert property (p_fhalt) else $error("fetch refused");
  property p_grant;
    store_grant |-> store_req.valid && exec_addr >= HALT_START;
  endproperty
  a_grant: assert property (p_grant)
    else $error("bad grant");
  property p_quiet; !store_grant |=> !prog_start; endproperty
  a_quiet: assert property (p_quiet) else $error("stray start");
  property p_lgr; load_grant |-> load_req; endproperty
  a_lgr: assert property (p_lgr) else $error("stray load");
endmodule
bind bfg_guard bfg_guard_asserts i_bfg_guard_asserts (
  .clock(clock), .rst_n(rst_n), .exec_addr(exec_addr),
  .store_req(store_req), .store_grant(store_grant), .load_req(load_req),
  .load_grant(load_grant), .fetch_addr(fetch_addr),
  .fetch_allow(fetch_allow), .core_stall(core_stall),
  .prog_start(prog_start), .prog_done(prog_done)
);

// *** bfg_flash_model.sv ***
// Flash array model that ends each erase or write after a fixed time
`timescale 1ns/1ns
module bfg_flash_model
  import bfg_pkg::*;
#(parameter int DLY = 8)
(
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  // Programming handshake
  input  wire logic            prog_start,
  input  wire bfg_store_kind_t prog_kind,
  output logic                 prog_done
);
  int   cnt = 0;
  logic done_q = 1'b0;
  assign prog_done = done_q;
  // Buffer loads get no answer; the array only times erase and write
  always @(posedge clock) begin
    done_q <= 1'b0;
    if (!rst_n) begin
      cnt <= 0;
    end else if (prog_start &&
                 prog_kind inside {ST_PAGE_ERASE, ST_PAGE_WRITE}) begin
      cnt <= DLY;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_q <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// *** tb_bfg_guard.sv ***
// Self-checking bench for the boot section flash guard
`timescale 1ns/1ns
module tb_bfg_guard
  import bfg_pkg::*;
;
  // Lock {boot hi, boot lo, app hi, app lo}, exec, target, and flags
  // {vectors in boot, store grant, load grant, interrupt mute}
  typedef struct packed {
    logic [3:0]  lock;
    logic [12:0] ex;
    logic [12:0] tg;
    logic [3:0]  f;
  } bfg_row_t;
  localparam logic [12:0] APP = 13'h0100;
  localparam logic [12:0] BLD = 13'h1e80;
  logic            clock = 1'b0;
  logic            rst_n = 1'b0;
  logic [3:0]      address = 4'h0;
  logic            read = 1'b0;
  logic            write = 1'b0;
  logic [31:0]     writedata = 32'h0;
  logic [12:0]     exec_addr = 13'h0;
  bfg_store_req_t  store_req = '0;
  logic            load_req = 1'b0;
  logic [12:0]     load_addr = 13'h0;
  logic [12:0]     fetch_addr = BLD;
  logic [1:0]      fuses = 2'h0;
  logic            chip_erase = 1'b0;
  logic            lk_stb = 1'b0;
  logic [3:0]      lk_dat = 4'h0;
  logic [31:0]     readdata, d;
  logic            waitrequest, store_grant, load_grant, fetch_allow;
  logic            core_stall, irq_suppress, prog_start, prog_done;
  bfg_store_kind_t prog_kind;
  logic [12:0]     prog_addr;
  logic            sg, lg, iq;
  int              error_cnt = 0;
  int              cmp_count = 0;
  bfg_row_t rows [11] = '{
    '{4'hf, BLD, APP, 4'h6},
    '{4'hf, BLD, BLD, 4'h6},
    '{4'hf, APP, APP, 4'h2},
    '{4'he, BLD, APP, 4'h2},
    '{4'hc, BLD, APP, 4'h0},
    '{4'hd, BLD, APP, 4'h4},
    '{4'hb, BLD, BLD, 4'h2},
    '{4'h3, APP, BLD, 4'h0},
    '{4'h7, APP, BLD, 4'h0},
    '{4'h7, BLD, BLD, 4'h7},
    '{4'hc, APP, APP, 4'hb}
  };
  // Fetches stay in the halting region while the other region programs
  bfg_guard i_bfg_guard (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest),
    .exec_addr(exec_addr), .store_req(store_req),
    .store_grant(store_grant), .load_req(load_req),
    .load_addr(load_addr), .load_grant(load_grant),
    .fetch_addr(fetch_addr), .fetch_allow(fetch_allow),
    .core_stall(core_stall), .irq_suppress(irq_suppress),
    .prog_start(prog_start), .prog_kind(prog_kind),
    .prog_addr(prog_addr), .prog_done(prog_done),
    .boot_size_fuses(fuses), .chip_erase(chip_erase),
    .lock_pgm_strobe(lk_stb), .lock_pgm_data(lk_dat)
  );
  bfg_flash_model i_bfg_flash_model (
    .clock(clock), .rst_n(rst_n), .prog_start(prog_start),
    .prog_kind(prog_kind), .prog_done(prog_done)
  );
  initial forever #25 clock = ~clock;
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do @(posedge clock); while (waitrequest);
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Erase pin is synchronised, so allow it time to land
  task automatic erase_chip();
    @(posedge clock);
    chip_erase <= 1'b1;
    @(posedge clock);
    chip_erase <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task automatic op(input bfg_store_kind_t k, input logic [12:0] ex, tg);
    @(posedge clock);
    exec_addr <= ex;
    load_addr <= tg;
    load_req <= 1'b1;
    store_req <= '{1'b1, k, tg, 4'hf};
    @(negedge clock);
    sg = store_grant;
    lg = load_grant;
    iq = irq_suppress;
    @(posedge clock);
    store_req.valid <= 1'b0;
    load_req <= 1'b0;
  endtask
  // Checks the command just taken, waits for its end, then probes the busy
  // flag through the status register and through a concurrent-region fetch
  task automatic done_busy(input logic exp, input logic [12:0] pg);
    @(negedge clock);
    chk(prog_start, 1'b1, "start pulse");
    chk(prog_addr, pg, "page address");
    chk(core_stall, !exp, "stall");
    chk(fetch_allow, exp, "halt fetch");
    while (!prog_done) @(posedge clock);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(d[ST_BUSY_BIT], exp, "busy flag");
    // Probe only: the answer is looked at, no code is taken from there
    fetch_addr <= APP;
    @(negedge clock);
    chk(fetch_allow, !exp, "busy fetch");
    @(posedge clock);
    fetch_addr <= BLD;
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b0, REG_LOCK, 32'h0);
    chk(d, 32'hf, "lock reset");
    foreach (rows[i]) begin
      erase_chip();
      bus(1'b1, REG_LOCK, {28'h0, rows[i].lock});
      bus(1'b1, REG_CONFIG, {31'h0, rows[i].f[3]});
      op(ST_PAGE_ERASE, rows[i].ex, rows[i].tg);
      chk({sg, lg, iq}, rows[i].f[2:0], "row");
      if (rows[i].f[2]) begin
        done_busy(rows[i].tg < HALT_START, rows[i].tg);
        bus(1'b1, REG_STATUS, 32'h10);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(d[ST_BUSY_BIT], 1'b0, "busy clear");
      end
    end
    // Ones written to the lock field must not unprogram anything
    bus(1'b1, REG_LOCK, 32'hf);
    bus(1'b0, REG_LOCK, 32'h0);
    chk(d, 32'hc, "lock kept");
    @(posedge clock);
    lk_dat <= 4'h7;
    lk_stb <= 1'b1;
    @(posedge clock);
    lk_stb <= 1'b0;
    repeat (8) @(posedge clock);
    bus(1'b0, REG_LOCK, 32'h0);
    chk(d, 32'h4, "pin lock");
    fuses <= 2'h3;
    erase_chip();
    bus(1'b0, REG_CONFIG, 32'h0);
    chk(d[5:4], 2'h3, "fuse read");
    op(ST_PAGE_ERASE, 13'h1e00, APP);
    chk(sg, 1'b0, "outside boot");
    op(ST_PAGE_ERASE, 13'h1fa0, APP);
    chk(sg, 1'b1, "small boot");
    done_busy(1'b1, APP);
    op(ST_BUF_LOAD, 13'h1fa0, APP);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(d[ST_BUSY_BIT], 1'b0, "load clears");
    // Page now below the small boot region, yet in the halting part
    op(ST_PAGE_WRITE, 13'h1fa0, BLD);
    chk(sg, 1'b1, "page write");
    done_busy(1'b0, BLD);
    // Lock set through a store from the boot region ANDs in its data
    @(posedge clock);
    store_req <= '{1'b1, ST_LOCK_SET, APP, 4'h9};
    @(posedge clock);
    store_req.valid <= 1'b0;
    bus(1'b0, REG_LOCK, 32'h0);
    chk(d, 32'h9, "store lock");
    bus(1'b0, 4'hc, 32'h0);
    chk(d, 32'h0, "unmapped");
    // Reset in mid-run returns locks and vectors to their start values
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, REG_LOCK, 32'h0);
    chk(d, 32'hf, "reset lock");
    bus(1'b0, REG_CONFIG, 32'h0);
    chk(d, 32'h30, "reset config");
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    wrap_up();
  end
endmodule
